// File: shared/wss_pkg.sv
// package of constants and types for the weld start sequencer
package wss_pkg;
    // ============
    // clock and timing
    // ============
    localparam int CLK_HZ = 200_000_000;
    localparam int CYC_PER_MS = CLK_HZ / 1000;
    localparam int DEBOUNCE_MS = 50;
    localparam int END_WELD_MS = 70;
    localparam int FS1_CALC_MS = 70;
    localparam int FS2_CALC_MS = 50;
    localparam int RESULT_CALC_MS = 35;
    localparam int DEBOUNCE_CYC = DEBOUNCE_MS * CYC_PER_MS;
    localparam int END_WELD_CYC = END_WELD_MS * CYC_PER_MS;
    localparam int FS1_CALC_CYC = FS1_CALC_MS * CYC_PER_MS;
    localparam int FS2_CALC_CYC = FS2_CALC_MS * CYC_PER_MS;
    localparam int RESULT_CALC_CYC = RESULT_CALC_MS * CYC_PER_MS;
    localparam int TW = 32;
    localparam int SCHED_W = 6;

    // ============
    // register map (byte addresses)
    // ============
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] STAT_OFS = 12'h004;
    localparam logic [11:0] IRQ_STAT_OFS = 12'h008;
    localparam logic [11:0] IRQ_MASK_OFS = 12'h00C;
    localparam logic [11:0] SQD_T_OFS = 12'h010;
    localparam logic [11:0] SQZ_T_OFS = 12'h014;
    localparam logic [11:0] WELD_T_OFS = 12'h018;
    localparam logic [11:0] COOL_T_OFS = 12'h01C;
    localparam logic [11:0] IMPULSE_OFS = 12'h020;

    // control fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_TWO_STAGE_BIT = 2;
    localparam int CTRL_ENABLE_BIT = 3;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0004;
    localparam logic [31:0] IMPULSE_RESET = 32'h0000_0001;
    localparam logic [31:0] PERIOD_RESET = 32'h0000_0064;

    // interrupt status bits
    localparam int IRQ_START_BIT = 0;
    localparam int IRQ_DONE_BIT = 1;
    localparam int IRQ_ABORT_BIT = 2;
    localparam int IRQ_W = 3;

    typedef enum logic [1:0] {
        WSS_PULSED,
        WSS_LATCHED,
        WSS_MAINTAINED,
        WSS_RSVD
    } wss_mode_t;

    typedef enum logic [3:0] {
        WSS_IDLE,
        WSS_CALC1,
        WSS_CALC2,
        WSS_SQD,
        WSS_SQZ,
        WSS_COOL,
        WSS_WELD,
        WSS_RESULT,
        WSS_EOW
    } wss_state_t;
endpackage

// File: hw/wss_debounce.sv
// debouncer with two-flop synchroniser for one footswitch input
module wss_debounce #(
    parameter int CYCLES = wss_pkg::DEBOUNCE_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // raw pin and clean level
    input wire logic raw,
    output logic clean
);
    localparam int TW = wss_pkg::TW;
    logic meta_q;
    logic sync_q;
    logic [wss_pkg::TW-1:0] cnt_q;

    // two-flop synchroniser
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end
        else
        begin
            meta_q <= raw;
            sync_q <= meta_q;
        end
    end

    // accept a change only after it stays stable for the interval
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            cnt_q <= '0;
            clean <= 1'b0;
        end
        else if (sync_q == clean)
            cnt_q <= '0;
        else if (cnt_q >= TW'(CYCLES - 1))
        begin
            cnt_q <= '0;
            clean <= sync_q;
        end
        else
            cnt_q <= cnt_q + 1'b1;
    end
endmodule

// File: hw/wss_ahb_regs.sv
// ahb-lite slave holding control, timing and interrupt registers
module wss_ahb_regs (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // ahb-lite
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // register values
    output logic [31:0] ctrl_q,
    output logic [31:0] sqd_q,
    output logic [31:0] sqz_q,
    output logic [31:0] weld_q,
    output logic [31:0] cool_q,
    output logic [31:0] impulse_q,
    output logic [2:0] irq_mask_q,
    output logic [2:0] irq_clr,
    // status readback
    input wire logic [2:0] irq_stat,
    input wire logic [31:0] status
);
    logic wr_pend_q;
    logic [11:0] wr_addr_q;
    logic rd_take;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign rd_take = hsel && hready && htrans[1] && !hwrite;
    // write-one-to-clear pulses in the data phase
    assign irq_clr = (wr_pend_q && wr_addr_q == wss_pkg::IRQ_STAT_OFS) ? hwdata[2:0] : 3'h0;

    // address phase capture
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 12'h000;
        end
        else
        begin
            wr_pend_q <= hsel && hready && htrans[1] && hwrite;
            wr_addr_q <= haddr[11:0];
        end
    end

    // write data phase
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ctrl_q <= wss_pkg::CTRL_RESET;
            sqd_q <= wss_pkg::PERIOD_RESET;
            sqz_q <= wss_pkg::PERIOD_RESET;
            weld_q <= wss_pkg::PERIOD_RESET;
            cool_q <= wss_pkg::PERIOD_RESET;
            impulse_q <= wss_pkg::IMPULSE_RESET;
            irq_mask_q <= 3'h0;
        end
        else if (wr_pend_q)
        begin
            case (wr_addr_q)
                wss_pkg::CTRL_OFS: ctrl_q <= hwdata;
                wss_pkg::SQD_T_OFS: sqd_q <= hwdata;
                wss_pkg::SQZ_T_OFS: sqz_q <= hwdata;
                wss_pkg::WELD_T_OFS: weld_q <= hwdata;
                wss_pkg::COOL_T_OFS: cool_q <= hwdata;
                wss_pkg::IMPULSE_OFS: impulse_q <= hwdata;
                wss_pkg::IRQ_MASK_OFS: irq_mask_q <= hwdata[2:0];
                default: ;
            endcase
        end
    end

    // read data registered for the data phase, unmapped reads zero
    always_ff @(posedge clk)
    begin
        if (srst)
            hrdata <= 32'h0000_0000;
        else if (rd_take)
        begin
            case (haddr[11:0])
                wss_pkg::CTRL_OFS: hrdata <= ctrl_q;
                wss_pkg::STAT_OFS: hrdata <= status;
                wss_pkg::IRQ_STAT_OFS: hrdata <= {29'h0, irq_stat};
                wss_pkg::IRQ_MASK_OFS: hrdata <= {29'h0, irq_mask_q};
                wss_pkg::SQD_T_OFS: hrdata <= sqd_q;
                wss_pkg::SQZ_T_OFS: hrdata <= sqz_q;
                wss_pkg::WELD_T_OFS: hrdata <= weld_q;
                wss_pkg::COOL_T_OFS: hrdata <= cool_q;
                wss_pkg::IMPULSE_OFS: hrdata <= impulse_q;
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule

// File: hw/wss_top.sv
// weld start sequencer top: footswitch start, hold modes, impulses, end of weld
// How it works
// [RQ1] debounce both footswitches, 30-70 ms, both edges
// [RQ2] pulsed: start held through squeeze period
// [RQ3] latched: start held only through squeeze delay
// [RQ4] maintained: start held for whole sequence
// [RQ5] maintained early release aborts weld at once
// [RQ6] end-of-weld held minimum, until starts released
// [RQ7] calculation latency after first, second stage closure
// [RQ8] result calculation time after each weld period
// [RQ9] first impulse weld only, then cool plus weld
// [RQ10] software selects one or two stage start
// [RQ11] six weighted select inputs give schedule 0-63
// [RQ12] schedule latched at start, held through sequence
//
// Implementation choices: the AHB-Lite interface to the registers and the address map.
module wss_top #(
    parameter int DEBOUNCE_CYC = wss_pkg::DEBOUNCE_CYC,
    parameter int END_WELD_CYC = wss_pkg::END_WELD_CYC,
    parameter int FS1_CALC_CYC = wss_pkg::FS1_CALC_CYC,
    parameter int FS2_CALC_CYC = wss_pkg::FS2_CALC_CYC,
    parameter int RESULT_CALC_CYC = wss_pkg::RESULT_CALC_CYC
) (
    // clock and reset
    input wire logic CLK,
    input wire logic SRST,
    // ahb-lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // footswitch and schedule select pins
    input wire logic FIRST_STAGE_FOOTSWITCH,
    input wire logic SECOND_STAGE_FOOTSWITCH,
    input wire logic [5:0] SCHEDULE_SELECT,
    // sequence outputs
    output logic SQUEEZE_ACTIVE,
    output logic WELD_ACTIVE,
    output logic END_OF_WELD,
    output logic [5:0] SCHEDULE,
    output logic IRQ
);
    localparam int TW = wss_pkg::TW;

    // ============
    // register file and pin conditioning
    // ============
    logic [31:0] ctrl_q;
    logic [31:0] sqd_q;
    logic [31:0] sqz_q;
    logic [31:0] weld_q;
    logic [31:0] cool_q;
    logic [31:0] impulse_q;
    logic [2:0] irq_mask_q;
    logic [2:0] irq_clr;
    logic [2:0] irq_stat_q;
    logic [31:0] status;
    logic fs1_db;
    logic fs2_db;
    logic [5:0] sel_meta_q;
    logic [5:0] sel_sync_q;
    logic hready_int;
    logic [31:0] hrdata_int;
    logic hresp_int;

    wss_ahb_regs u_regs (
        .clk(CLK),
        .srst(SRST),
        .hsel(HSEL),
        .haddr(HADDR),
        .htrans(HTRANS),
        .hwrite(HWRITE),
        .hsize(HSIZE),
        .hwdata(HWDATA),
        .hready(HREADY),
        .hrdata(hrdata_int),
        .hreadyout(hready_int),
        .hresp(hresp_int),
        .ctrl_q(ctrl_q),
        .sqd_q(sqd_q),
        .sqz_q(sqz_q),
        .weld_q(weld_q),
        .cool_q(cool_q),
        .impulse_q(impulse_q),
        .irq_mask_q(irq_mask_q),
        .irq_clr(irq_clr),
        .irq_stat(irq_stat_q),
        .status(status)
    );

    // bus answer: read data comes from a flop inside the slave
    assign HRDATA = hrdata_int;

    // ready and response registered so every pin leaves a flop
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end
        else
        begin
            HREADYOUT <= hready_int;
            HRESP <= hresp_int;
        end
    end

    // debounce both footswitches on open and close
    wss_debounce #(.CYCLES(DEBOUNCE_CYC)) u_db1 (  // [RQ1]
        .clk(CLK),
        .srst(SRST),
        .raw(FIRST_STAGE_FOOTSWITCH),
        .clean(fs1_db)
    );
    wss_debounce #(.CYCLES(DEBOUNCE_CYC)) u_db2 (  // [RQ1]
        .clk(CLK),
        .srst(SRST),
        .raw(SECOND_STAGE_FOOTSWITCH),
        .clean(fs2_db)
    );

    // schedule select synchroniser
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            sel_meta_q <= 6'h00;
            sel_sync_q <= 6'h00;
        end
        else
        begin
            sel_meta_q <= SCHEDULE_SELECT;
            sel_sync_q <= sel_meta_q;
        end
    end

    // ============
    // start decode
    // ============
    wss_pkg::wss_mode_t mode;
    logic two_stage;
    logic enable;
    logic start_ok;
    logic any_start;

    assign mode = wss_pkg::wss_mode_t'(ctrl_q[wss_pkg::CTRL_MODE_LSB +: 2]);
    assign two_stage = ctrl_q[wss_pkg::CTRL_TWO_STAGE_BIT];  // [RQ10]
    assign enable = ctrl_q[wss_pkg::CTRL_ENABLE_BIT];
    // one-stage uses only the first footswitch
    assign start_ok = two_stage ? (fs1_db && fs2_db) : fs1_db;  // [RQ10]
    assign any_start = fs1_db || fs2_db;

    // ============
    // sequence state machine
    // ============
    wss_pkg::wss_state_t state_q;
    logic [TW-1:0] tmr_q;
    logic [TW-1:0] imp_q;
    logic [TW-1:0] imp_total;
    logic tmr_done;
    logic hold_lost;
    logic ev_start;
    logic ev_done;
    logic ev_abort;

    // timer expiry; zero impulses run as one
    assign tmr_done = (tmr_q == '0);
    assign imp_total = (impulse_q == 32'h0) ? 32'h1 : impulse_q;

    // early release: pulsed through squeeze, latched through squeeze delay, maintained always
    always_comb
    begin
        hold_lost = 1'b0;
        case (state_q)
            wss_pkg::WSS_CALC2, wss_pkg::WSS_SQD:
                hold_lost = !start_ok;  // [RQ2] [RQ3] [RQ4]
            wss_pkg::WSS_SQZ:
                hold_lost = !start_ok && (mode != wss_pkg::WSS_LATCHED);  // [RQ2] [RQ3]
            wss_pkg::WSS_COOL, wss_pkg::WSS_WELD, wss_pkg::WSS_RESULT:
                hold_lost = !start_ok && (mode == wss_pkg::WSS_MAINTAINED);  // [RQ5]
            default:
                hold_lost = 1'b0;
        endcase
    end

    // interrupt events
    assign ev_start = (state_q == wss_pkg::WSS_IDLE) && enable && fs1_db;
    assign ev_abort = hold_lost;
    assign ev_done = (state_q == wss_pkg::WSS_RESULT) && tmr_done && (imp_q <= 32'h1) && !hold_lost;

    // state and period timer
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            state_q <= wss_pkg::WSS_IDLE;
            tmr_q <= '0;
            imp_q <= '0;
        end
        else if (hold_lost)
        begin
            // terminate immediately, end-of-weld stays low
            state_q <= wss_pkg::WSS_IDLE;  // [RQ5]
            tmr_q <= '0;
        end
        else
        begin
            if (!tmr_done)
                tmr_q <= tmr_q - 1'b1;
            case (state_q)
                wss_pkg::WSS_IDLE:
                    if (ev_start)
                    begin
                        state_q <= wss_pkg::WSS_CALC1;
                        tmr_q <= TW'(FS1_CALC_CYC);  // [RQ7]
                        imp_q <= imp_total;
                    end
                wss_pkg::WSS_CALC1:
                    if (!fs1_db)
                        state_q <= wss_pkg::WSS_IDLE;
                    else if (tmr_done && start_ok)
                    begin
                        state_q <= wss_pkg::WSS_CALC2;
                        tmr_q <= two_stage ? TW'(FS2_CALC_CYC) : '0;  // [RQ7]
                    end
                wss_pkg::WSS_CALC2:
                    if (tmr_done)
                    begin
                        state_q <= wss_pkg::WSS_SQD;
                        tmr_q <= sqd_q;
                    end
                wss_pkg::WSS_SQD:
                    if (tmr_done)
                    begin
                        state_q <= wss_pkg::WSS_SQZ;
                        tmr_q <= sqz_q;
                    end
                wss_pkg::WSS_SQZ:
                    if (tmr_done)
                    begin
                        // first impulse is a weld period only
                        state_q <= wss_pkg::WSS_WELD;  // [RQ9]
                        tmr_q <= weld_q;
                    end
                wss_pkg::WSS_COOL:
                    if (tmr_done)
                    begin
                        state_q <= wss_pkg::WSS_WELD;  // [RQ9]
                        tmr_q <= weld_q;
                    end
                wss_pkg::WSS_WELD:
                    if (tmr_done)
                    begin
                        state_q <= wss_pkg::WSS_RESULT;
                        tmr_q <= TW'(RESULT_CALC_CYC);  // [RQ8]
                    end
                wss_pkg::WSS_RESULT:
                    if (tmr_done)
                    begin
                        if (imp_q > 32'h1)
                        begin
                            // later impulses: cool then weld
                            state_q <= wss_pkg::WSS_COOL;  // [RQ9]
                            tmr_q <= cool_q;
                            imp_q <= imp_q - 1'b1;
                        end
                        else
                        begin
                            state_q <= wss_pkg::WSS_EOW;
                            tmr_q <= TW'(END_WELD_CYC);  // [RQ6]
                        end
                    end
                wss_pkg::WSS_EOW:
                    if (tmr_done && !any_start)
                        state_q <= wss_pkg::WSS_IDLE;  // [RQ6]
                default:
                    state_q <= wss_pkg::WSS_IDLE;
            endcase
        end
    end

    // ============
    // schedule capture
    // ============
    always_ff @(posedge CLK)
    begin
        if (SRST)
            SCHEDULE <= 6'h00;
        else if (ev_start)
            SCHEDULE <= sel_sync_q;  // [RQ11] [RQ12]
    end

    // ============
    // registered outputs
    // ============
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            SQUEEZE_ACTIVE <= 1'b0;
            WELD_ACTIVE <= 1'b0;
            END_OF_WELD <= 1'b0;
        end
        else
        begin
            SQUEEZE_ACTIVE <= (state_q == wss_pkg::WSS_SQD) || (state_q == wss_pkg::WSS_SQZ);
            WELD_ACTIVE <= (state_q == wss_pkg::WSS_WELD) && !hold_lost;  // [RQ5]
            END_OF_WELD <= (state_q == wss_pkg::WSS_EOW);  // [RQ6]
        end
    end

    // ============
    // interrupts: sticky status, set wins over clear
    // ============
    logic [2:0] ev_vec;

    assign ev_vec = {ev_abort, ev_done, ev_start};

    always_ff @(posedge CLK)
    begin
        if (SRST)
            irq_stat_q <= 3'h0;
        else
            irq_stat_q <= (irq_stat_q & ~irq_clr) | ev_vec;
    end

    always_ff @(posedge CLK)
    begin
        if (SRST)
            IRQ <= 1'b0;
        else
            IRQ <= |(((irq_stat_q & ~irq_clr) | ev_vec) & irq_mask_q);
    end

    // status word: state, debounced inputs, schedule, impulses left
    assign status = {imp_q[7:0], 10'h000, SCHEDULE, fs2_db, fs1_db, 2'b00, state_q};
endmodule

// File: dv/wss_fsw_model.sv
// footswitch and schedule select model standing in for the operator
module wss_fsw_model (
    // clock
    input wire logic clk,
    // commands from the bench
    input wire logic press,
    input wire logic two,
    input wire logic [5:0] sel_in,
    // pins toward the sequencer
    output logic fs1 = 1'b0,
    output logic fs2 = 1'b0,
    output logic [5:0] sel = 6'h00
);
    timeunit 1ns;
    timeprecision 1ps;
    logic press_q = 1'b0;
    int bnc_q = 0;
    // ============
    // contacts
    // ============
    // contacts chatter for six cycles after every change of the press
    always @(posedge clk)
    begin
        press_q <= press;
        bnc_q <= (press != press_q) ? 6 : ((bnc_q > 0) ? bnc_q - 1 : 0);
    end
    // start held as long as the bench presses, second stage only when fitted
    always @(posedge clk)
    begin
        fs1 <= (bnc_q > 0) ? ~fs1 : press_q;
        fs2 <= two && ((bnc_q > 0) ? ~fs1 : press_q);
        sel <= sel_in;
    end
endmodule

// File: dv/wss_top_asserts.sv
// port checker for the weld start sequencer
// ============
// checker
// ============
module wss_top_asserts #(
    parameter int DEBOUNCE_CYC = 20,
    parameter int END_WELD_CYC = 30,
    parameter int FS1_CALC_CYC = 10,
    parameter int RESULT_CALC_CYC = 5
) (
    // clock and reset
    input wire logic CLK,
    input wire logic SRST,
    // footswitch pins
    input wire logic FIRST_STAGE_FOOTSWITCH,
    input wire logic SECOND_STAGE_FOOTSWITCH,
    // sequence outputs
    input wire logic SQUEEZE_ACTIVE,
    input wire logic WELD_ACTIVE,
    input wire logic END_OF_WELD,
    input wire logic [5:0] SCHEDULE
);
    default clocking @(posedge CLK);
    endclocking
    default disable iff (SRST);
    int eow_n_q;
    int gap_q;
    int fs_n_q;
    // run lengths: end of weld high, weld low, first stage high
    always_ff @(posedge CLK)
    begin
        eow_n_q <= (SRST || !END_OF_WELD) ? 0 : eow_n_q + 1;
        gap_q <= (SRST || WELD_ACTIVE) ? 0 : ((gap_q < 9999) ? gap_q + 1 : gap_q);
        fs_n_q <= (SRST || !FIRST_STAGE_FOOTSWITCH) ? 0 : fs_n_q + 1;
    end
    // end of weld timing
    chk_eow_min: assert property ($fell(END_OF_WELD) |-> eow_n_q >= END_WELD_CYC)
        else $error("end of weld too short");
    chk_eow_pins: assert property ($fell(END_OF_WELD) |-> !FIRST_STAGE_FOOTSWITCH && !SECOND_STAGE_FOOTSWITCH)
        else $error("end of weld dropped with start held");
    chk_eow_ends: assert property (END_OF_WELD && $fell(FIRST_STAGE_FOOTSWITCH) |-> ##[1:100] !END_OF_WELD)
        else $error("end of weld stuck after release");
    chk_weld_eow: assert property (END_OF_WELD |-> !WELD_ACTIVE && !SQUEEZE_ACTIVE)
        else $error("end of weld during weld");
    // sequence order and latencies
    chk_sched_hold: assert property (WELD_ACTIVE || END_OF_WELD |-> $stable(SCHEDULE))
        else $error("schedule moved in sequence");
    chk_sqz_weld: assert property (!(SQUEEZE_ACTIVE && WELD_ACTIVE))
        else $error("squeeze and weld together");
    chk_start_wait: assert property ($rose(SQUEEZE_ACTIVE) |-> fs_n_q >= DEBOUNCE_CYC + FS1_CALC_CYC)
        else $error("squeeze before debounce and latency");
    chk_result_gap: assert property ($rose(END_OF_WELD) |-> gap_q >= RESULT_CALC_CYC)
        else $error("no result time after weld");
    chk_first_weld: assert property ($fell(SQUEEZE_ACTIVE) && FIRST_STAGE_FOOTSWITCH |-> ##[0:2] WELD_ACTIVE)
        else $error("first impulse not a weld");
    // main scenarios
    cover property ($rose(SQUEEZE_ACTIVE));
    cover property ($rose(WELD_ACTIVE));
    cover property ($fell(END_OF_WELD));
endmodule

bind wss_top wss_top_asserts #(
    .DEBOUNCE_CYC(DEBOUNCE_CYC),
    .END_WELD_CYC(END_WELD_CYC),
    .FS1_CALC_CYC(FS1_CALC_CYC),
    .RESULT_CALC_CYC(RESULT_CALC_CYC)
) wss_top_asserts_i (
    .CLK(CLK), .SRST(SRST),
    .FIRST_STAGE_FOOTSWITCH(FIRST_STAGE_FOOTSWITCH), .SECOND_STAGE_FOOTSWITCH(SECOND_STAGE_FOOTSWITCH),
    .SQUEEZE_ACTIVE(SQUEEZE_ACTIVE), .WELD_ACTIVE(WELD_ACTIVE),
    .END_OF_WELD(END_OF_WELD), .SCHEDULE(SCHEDULE)
);

// File: dv/tb.sv
// self-checking bench for the weld start sequencer
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ============
    // signals
    // ============
    logic CLK = 1'b0;
    logic SRST = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [2:0] hsize = 3'h0;
    logic press = 1'b0;
    logic two = 1'b1;
    logic [5:0] sel_in = 6'h00;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic fs1;
    logic fs2;
    logic [5:0] sel;
    logic squeeze_period;
    logic weld;
    logic eow;
    logic irq;
    logic [5:0] sched;
    logic [5:0] sels [3] = '{6'h29, 6'h16, 6'h3F};
    int n_errors = 0;
    int num_checks = 0;
    int k;
    // 200 MHz clock
    always #2.5 CLK = ~CLK;
    // ============
    // design and operator model
    // ============
    wss_top #(
        .DEBOUNCE_CYC(20), .END_WELD_CYC(30), .FS1_CALC_CYC(10), .FS2_CALC_CYC(10), .RESULT_CALC_CYC(5)
    ) wss_top_i (
        .CLK(CLK), .SRST(SRST),
        .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
        .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
        .FIRST_STAGE_FOOTSWITCH(fs1), .SECOND_STAGE_FOOTSWITCH(fs2), .SCHEDULE_SELECT(sel),
        .SQUEEZE_ACTIVE(squeeze_period), .WELD_ACTIVE(weld), .END_OF_WELD(eow), .SCHEDULE(sched), .IRQ(irq)
    );
    wss_fsw_model wss_fsw_model_i (
        .clk(CLK), .press(press), .two(two), .sel_in(sel_in), .fs1(fs1), .fs2(fs2), .sel(sel)
    );
    // ============
    // tasks
    // ============
    // compare and count
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one ahb-lite single transfer, address phase then data phase
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {20'h0, a};
        hwrite <= wr;
        hsize <= 3'h2;
        do @(posedge CLK); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge CLK); while (hreadyout !== 1'b1);
        q = hrdata;
        check("hresp", 32'h0, {31'h0, hresp});
    endtask
    // register write
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    // register read and compare
    task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(nm, e, q);
    endtask
    // bounded wait for a level, then compare it
    task automatic wlvl(input string nm, ref logic s, input logic v, input int lim);
        int n;
        n = 0;
        while (s !== v && n < lim)
        begin
            @(posedge CLK);
            n++;
        end
        check(nm, {31'h0, v}, {31'h0, s});
    endtask
    // idle cycles
    task automatic cyc(input int n);
        repeat (n) @(posedge CLK);
    endtask
    // verdict and end of run
    task automatic end_of_test;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // watchdog against a hang
    initial
    begin
        cyc(20000);
        n_errors++;
        end_of_test();
    end
    // ============
    // tests
    // ============
    initial
    begin
        cyc(8);
        SRST <= 1'b0;
        @(posedge CLK);
        // reset values, unmapped place, set-up
        rchk("ctrl", wss_pkg::CTRL_OFS, wss_pkg::CTRL_RESET);
        rchk("sqd", wss_pkg::SQD_T_OFS, wss_pkg::PERIOD_RESET);
        rchk("imp", wss_pkg::IMPULSE_OFS, wss_pkg::IMPULSE_RESET);
        wr(12'h040, 32'hFFFF_FFFF);
        rchk("unmapped", 12'h040, 32'h0);
        wr(wss_pkg::SQD_T_OFS, 32'h3);
        wr(wss_pkg::SQZ_T_OFS, 32'h3);
        wr(wss_pkg::WELD_T_OFS, 32'h3C);
        wr(wss_pkg::COOL_T_OFS, 32'h3);
        wr(wss_pkg::IRQ_MASK_OFS, 32'h7);
        wr(wss_pkg::CTRL_OFS, 32'hC);
        rchk("ctrl", wss_pkg::CTRL_OFS, 32'hC);
        // press shorter than the debounce time is ignored
        press <= 1'b1;
        cyc(12);
        press <= 1'b0;
        cyc(60);
        rchk("glitch", wss_pkg::IRQ_STAT_OFS, 32'h0);
        // each hold mode, start released during the weld
        for (k = 0; k < 3; k++)
        begin
            wr(wss_pkg::CTRL_OFS, 32'hC | k);
            sel_in <= sels[k];
            press <= 1'b1;
            wlvl("squeeze", squeeze_period, 1'b1, 400);
            check("sched", {26'h0, sels[k]}, {26'h0, sched});
            sel_in <= ~sels[k];
            wlvl("weld", weld, 1'b1, 400);
            press <= 1'b0;
            if (k < 2)
            begin
                wlvl("eow", eow, 1'b1, 400);
                check("held sched", {26'h0, sels[k]}, {26'h0, sched});
                wlvl("eow off", eow, 1'b0, 100);
                rchk("irq done", wss_pkg::IRQ_STAT_OFS, 32'h3);
            end
            else
            begin
                wlvl("abort", weld, 1'b0, 40);
                cyc(100);
                check("no eow", 32'h0, {31'h0, eow});
                rchk("irq abort", wss_pkg::IRQ_STAT_OFS, 32'h5);
            end
            check("irq pin", 32'h1, {31'h0, irq});
            wr(wss_pkg::IRQ_STAT_OFS, 32'h7);
            cyc(2);
            check("irq clear", 32'h0, {31'h0, irq});
        end
        // three impulses, start held, end of weld kept while held
        wr(wss_pkg::IMPULSE_OFS, 32'h3);
        wr(wss_pkg::CTRL_OFS, 32'hE);
        press <= 1'b1;
        for (k = 0; k < 3; k++)
        begin
            wlvl("impulse", weld, 1'b1, 400);
            wlvl("impulse end", weld, 1'b0, 100);
        end
        wlvl("eow", eow, 1'b1, 20);
        cyc(60);
        check("eow held", 32'h1, {31'h0, eow});
        press <= 1'b0;
        wlvl("eow off", eow, 1'b0, 60);
        // second stage missing, then one-stage start
        wr(wss_pkg::IMPULSE_OFS, 32'h1);
        wr(wss_pkg::CTRL_OFS, 32'hC);
        two <= 1'b0;
        press <= 1'b1;
        cyc(150);
        check("no squeeze", 32'h0, {31'h0, squeeze_period});
        press <= 1'b0;
        cyc(60);
        wr(wss_pkg::CTRL_OFS, 32'h8);
        press <= 1'b1;
        wlvl("one stage", squeeze_period, 1'b1, 200);
        wlvl("eow", eow, 1'b1, 400);
        press <= 1'b0;
        wlvl("eow off", eow, 1'b0, 100);
        rchk("stat", wss_pkg::STAT_OFS, 32'h0100_0000);
        end_of_test();
    end
endmodule
